//--- hw/program_counter_return_stack.sv
// Program counter sequencer with hardware return stack and AHB-Lite register slave.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module program_counter_return_stack
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [pcs_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [pcs_pkg::HDATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [pcs_pkg::HDATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic step,
    input wire logic call_valid,
    input wire logic [pcs_pkg::PC_W-1:0] call_target,
    input wire logic ret_valid,
    input wire logic irq_accept,
    output logic [pcs_pkg::PC_W-1:0] pc,
    output logic [pcs_pkg::PROG_AW-1:0] fetch_addr,
    output logic [pcs_pkg::SP_W-1:0] stack_level
);
    import pcs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        logic [PC_W-1:0] pc;
        logic [SP_W-1:0] sp;
        bus_state_t bus;
        logic ready;
        logic wr;
        logic [HADDR_W-1:0] addr;
        logic [HDATA_W-1:0] rdata;
        logic touched;
    } seq_state_t;

    seq_state_t st;
    seq_state_t nx;
    logic push;
    logic pop;
    logic accept;
    logic [PC_W-1:0] tos;

    stack_port_if #(.AW(SP_W), .DW(PC_W)) sport ();

    return_stack_ram #(.DEPTH(STACK_DEPTH), .AW(SP_W), .DW(PC_W)) u_ram
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .mem_port(sport.mem)
    );

    function automatic logic hits(input logic [HADDR_W-1:0] a, input logic [HADDR_W-1:0] reg_addr);
        return a[HADDR_W-1:2] == reg_addr[HADDR_W-1:2];
    endfunction

    function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
        return PC_W'(p + 1'b1);
    endfunction

    // The read port always looks at the current top, so the next-state logic never feeds its own read address.
    assign sport.raddr = st.sp;
    assign tos = sport.rdata;
    assign push = irq_accept | call_valid;
    assign pop = ret_valid & ~push;
    assign accept = hsel & htrans[1] & hready;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Core operations win over a bus write landing in the same cycle; the
    // stack has one write port and the running program must never be corrupted.
    always_comb
    begin
        nx = st;
        sport.we = 1'b0;
        sport.waddr = st.sp;
        sport.wdata = tos;

        unique case (st.bus)
            BUS_IDLE:
            begin
                nx.ready = 1'b1;
                if (accept)
                begin
                    nx.bus = BUS_WAIT;
                    nx.ready = 1'b0;
                    nx.wr = hwrite;
                    nx.addr = haddr;
                end
            end
            BUS_WAIT:
            begin
                nx.bus = BUS_IDLE;
                nx.ready = 1'b1;
                nx.rdata = '0;
                if (st.wr)
                begin
                    if (hits(st.addr, ADDR_STACK_LEVEL_POINTER))
                    begin
                        nx.sp = hwdata[SP_W-1:0];
                    end
                    else if (hits(st.addr, ADDR_STACK_TOP_LOW_BYTE))
                    begin
                        sport.we = 1'b1;
                        sport.wdata = {tos[PC_W-1:TOP_HIGH_LSB], hwdata[REG_W-1:0]};
                    end
                    else if (hits(st.addr, ADDR_STACK_TOP_HIGH_BYTE))
                    begin
                        sport.we = 1'b1;
                        sport.wdata = {hwdata[TOP_HIGH_W-1:0], tos[TOP_HIGH_LSB-1:0]};
                    end
                end
                else if (hits(st.addr, ADDR_STACK_LEVEL_POINTER))
                begin
                    nx.rdata = HDATA_W'(st.sp);
                end
                else if (hits(st.addr, ADDR_STACK_TOP_LOW_BYTE))
                begin
                    nx.rdata = HDATA_W'(tos[TOP_HIGH_LSB-1:0]);
                end
                else if (hits(st.addr, ADDR_STACK_TOP_HIGH_BYTE))
                begin
                    nx.rdata = HDATA_W'(tos[PC_W-1:TOP_HIGH_LSB]);
                end
            end
        endcase

        if (push | pop | step)
        begin
            nx.touched = 1'b1;
        end

        if (push)
        begin
            sport.we = 1'b1;
            sport.waddr = SP_W'(st.sp + 1'b1);
            nx.sp = SP_W'(st.sp + 1'b1);
            if (irq_accept)
            begin
                sport.wdata = st.pc;
                nx.pc = IRQ_VECTOR;
            end
            else
            begin
                sport.wdata = pc_inc(st.pc);
                nx.pc = call_target;
            end
        end
        else if (pop)
        begin
            sport.we = 1'b0;
            nx.pc = tos;
            nx.sp = SP_W'(st.sp - 1'b1);
        end
        else if (step)
        begin
            nx.pc = pc_inc(st.pc);
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st.pc <= RESET_VECTOR;
            st.sp <= SP_EMPTY;
            st.bus <= BUS_IDLE;
            st.ready <= 1'b1;
            st.wr <= 1'b0;
            st.addr <= '0;
            st.rdata <= '0;
            st.touched <= 1'b0;
        end
        else
        begin
            st <= nx;
        end
    end

    assign hrdata = st.rdata;
    assign hreadyout = st.ready;
    assign hresp = HRESP_OKAY;
    assign pc = st.pc;
    // Fetch wraps inside the implemented space; bits above it are ignored.
    assign fetch_addr = st.pc[PROG_AW-1:0];
    assign stack_level = st.sp;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_push;
        push;
    endsequence

    sequence s_fill_seven;
        (push && st.sp == SP_EMPTY) ##1 push [*6];
    endsequence

    sequence s_push_then_pop;
        s_push ##1 pop;
    endsequence

    AST_RESET_STATE: assert property (!st.touched && !sport.we |-> st.pc == RESET_VECTOR)
        else $error("Counter left reset vector without a core operation.");
    AST_IRQ_VECTOR: assert property (irq_accept |=> st.pc == IRQ_VECTOR && tos == $past(st.pc))
        else $error("Interrupt entry did not save address and vector.");
    AST_FETCH_WRAP: assert property (step && !push && !pop && fetch_addr == LAST_PROG_ADDR |=> fetch_addr == '0)
        else $error("Fetch address did not wrap past the last word.");
    AST_FIRST_PUSH: assert property (push && st.sp == SP_EMPTY |-> sport.waddr == '0 ##1 st.sp == '0)
        else $error("First push did not land in entry zero.");
    AST_PUSH_ADVANCE: assert property (s_push |=> st.sp == SP_W'($past(st.sp) + 1'b1))
        else $error("Push did not advance the pointer by one.");
    AST_SEVEN_PUSHES: assert property (s_fill_seven |=> st.sp == SP_SEVENTH)
        else $error("Seven pushes did not leave the pointer at six.");
    AST_RETURN_LOAD: assert property (pop |=> st.pc == $past(tos) && st.sp == SP_W'($past(st.sp) - 1'b1))
        else $error("Return did not reload counter and drop pointer.");
    AST_UNWIND: assert property (s_push_then_pop |=> st.pc == $past(sport.wdata, 2))
        else $error("Return did not recover the address just pushed.");
    AST_EMPTY_PTR: assert property (!st.touched && !(st.bus == BUS_WAIT && st.wr) |-> st.sp == SP_EMPTY)
        else $error("Pointer not at empty value before any push.");
    AST_BUS_WAIT: assert property (accept && st.bus == BUS_IDLE |=> !hreadyout ##1 hreadyout)
        else $error("Bus transfer did not complete after one wait state.");

endmodule

//--- hw/pcs_pkg.sv
// Constants and types shared by the program counter and return stack design.
//
// Summary of operation
// - Program counter is fifteen bits wide.
// - Any reset loads the counter with 0000h.
// - Interrupt pushes return address, then jumps 0004h.
// - Program memory holds 8192 words, last 1FFFh.
// - First push fills entry zero, pointer 0x00.
// - Each push advances pointer; seven give 0x06.
// - Return reloads counter from top, pointer decrements.
package pcs_pkg;

    // ****************************************************************
    // Program counter
    // ****************************************************************
    localparam int PC_W = 15;
    localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;
    localparam int PROG_WORDS = 8192;
    localparam int PROG_AW = $clog2(PROG_WORDS);
    localparam logic [PROG_AW-1:0] LAST_PROG_ADDR = 13'h1FFF;

    // ****************************************************************
    // Return stack
    // ****************************************************************
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam logic [SP_W-1:0] SP_EMPTY = 4'hF;
    localparam logic [SP_W-1:0] SP_SEVENTH = 4'h6;

    // ****************************************************************
    // Register map: each index is a word number, so the byte address is four times it.
    // ****************************************************************
    localparam int HADDR_W = 16;
    localparam int HDATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [HADDR_W-1:0] IDX_STACK_LEVEL_POINTER = 16'h1FED;
    localparam logic [HADDR_W-1:0] IDX_STACK_TOP_LOW_BYTE = 16'h1FEE;
    localparam logic [HADDR_W-1:0] IDX_STACK_TOP_HIGH_BYTE = 16'h1FEF;
    localparam logic [HADDR_W-1:0] ADDR_STACK_LEVEL_POINTER = HADDR_W'(IDX_STACK_LEVEL_POINTER * 4);
    localparam logic [HADDR_W-1:0] ADDR_STACK_TOP_LOW_BYTE = HADDR_W'(IDX_STACK_TOP_LOW_BYTE * 4);
    localparam logic [HADDR_W-1:0] ADDR_STACK_TOP_HIGH_BYTE = HADDR_W'(IDX_STACK_TOP_HIGH_BYTE * 4);
    localparam int TOP_HIGH_LSB = 8;
    localparam int TOP_HIGH_W = PC_W - TOP_HIGH_LSB;

    // ****************************************************************
    // AHB-Lite encodings
    // ****************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic
    {
        BUS_IDLE = 1'b0,
        BUS_WAIT = 1'b1
    } bus_state_t;

endpackage

//--- hw/stack_port_if.sv
// Interface between the sequencer and its return-address storage.
`timescale 1ns/10ps
interface stack_port_if
#(
    parameter int AW = 4,
    parameter int DW = 15
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctl
    (
        output we,
        output waddr,
        output wdata,
        output raddr,
        input rdata
    );

    modport mem
    (
        input we,
        input waddr,
        input wdata,
        input raddr,
        output rdata
    );
endinterface

//--- hw/return_stack_ram.sv
// Return-address storage: one write port, one combinational read port.
`timescale 1ns/10ps
module return_stack_ram
#(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int DW = 15
)
(
    input wire logic hclk,
    input wire logic hresetn,
    stack_port_if.mem mem_port
);
    import pcs_pkg::*;

    typedef struct packed
    {
        logic [DEPTH-1:0][DW-1:0] entry;
    } ram_state_t;

    ram_state_t st;
    ram_state_t nx;

    always_comb
    begin
        nx = st;
        if (mem_port.we)
        begin
            nx.entry[mem_port.waddr] = mem_port.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= nx;
        end
    end

    assign mem_port.rdata = st.entry[mem_port.raddr];

endmodule

//--- tb/core_model.sv
// Behavioural model of the instruction core that drives the sequencer's control inputs.
`timescale 1ns/10ps
module core_model
(
    input wire logic hclk,
    output logic step,
    output logic call_valid,
    output logic [pcs_pkg::PC_W-1:0] call_target,
    output logic ret_valid,
    output logic irq_accept
);
    import pcs_pkg::*;
    initial
    begin
        step = 1'b0;
        call_valid = 1'b0;
        call_target = '0;
        ret_valid = 1'b0;
        irq_accept = 1'b0;
    end
    // Kind 0 steps, 1 calls, 2 returns, 3 takes an interrupt, 4 idles.
    // Kind 5 raises a call with an interrupt and kind 6 a return with a step, so the priority is exercised.
    task automatic issue(input int kind, input logic [PC_W-1:0] target);
        step <= (kind == 0) || (kind == 6);
        call_valid <= (kind == 1) || (kind == 5);
        call_target <= (kind == 1 || kind == 5) ? target : ~target;
        ret_valid <= (kind == 2) || (kind == 6);
        irq_accept <= (kind == 3) || (kind == 5);
    endtask
endmodule

//--- tb/program_counter_return_stack_tb_top.sv
// Self-checking bench for the program counter and return stack.
`timescale 1ns/10ps
module program_counter_return_stack_tb_top;
    import pcs_pkg::*;
    typedef struct {int k; logic [14:0] t; logic [14:0] pc; logic [3:0] sp;} row_t;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic step, call_valid, ret_valid, irq_accept;
    logic [15:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [14:0] call_target, pc;
    logic [12:0] fetch_addr;
    logic [3:0] stack_level;
    int fail_count = 0;
    int check_count = 0;
    row_t rows [17] = '{'{0, 0, 15'h0001, 4'hF}, '{1, 15'h0100, 15'h0100, 4'h0}, '{3, 0, 15'h0004, 4'h1},
        '{1, 15'h1FFF, 15'h1FFF, 4'h2}, '{0, 0, 15'h2000, 4'h2}, '{1, 15'h7FFF, 15'h7FFF, 4'h3},
        '{0, 0, 15'h0000, 4'h3}, '{1, 15'h0010, 15'h0010, 4'h4}, '{1, 15'h0020, 15'h0020, 4'h5},
        '{1, 15'h0030, 15'h0030, 4'h6}, '{2, 0, 15'h0021, 4'h5}, '{2, 0, 15'h0011, 4'h4},
        '{2, 0, 15'h0001, 4'h3}, '{2, 0, 15'h2001, 4'h2}, '{2, 0, 15'h0005, 4'h1},
        '{2, 0, 15'h0100, 4'h0}, '{2, 0, 15'h0002, 4'hF}};
    assign hready = hreadyout;
    program_counter_return_stack u_dut
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .step(step),
        .call_valid(call_valid),
        .call_target(call_target),
        .ret_valid(ret_valid),
        .irq_accept(irq_accept),
        .pc(pc),
        .fetch_addr(fetch_addr),
        .stack_level(stack_level)
    );
    core_model u_core
    (
        .hclk(hclk),
        .step(step),
        .call_valid(call_valid),
        .call_target(call_target),
        .ret_valid(ret_valid),
        .irq_accept(irq_accept)
    );
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Registered outputs are read at the falling edge, where they equal what the next rising edge samples.
    // The wait is open ended; only the watchdog ends a hang. The count of edges is then held against the expected count exp_n.
    task automatic wait_ready(input int exp_n, output logic [31:0] data);
        int n;
        logic ok;
        n = 0;
        do
        begin
            @(negedge hclk);
            ok = hreadyout;
            data = hrdata;
            @(posedge hclk);
            n++;
        end
        while (ok !== 1'b1);
        chk(32'(n), 32'(exp_n));
        chk(32'(hresp), 32'(HRESP_OKAY));
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic [31:0] exp);
        logic [31:0] data;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_ready(1, data);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(2, data);
        if (!w)
            chk(data, exp);
    endtask
    task automatic op(input int k, input logic [14:0] t, input logic [14:0] epc, input logic [3:0] esp);
        u_core.issue(k, t);
        @(posedge hclk);
        u_core.issue(4, t);
        @(negedge hclk);
        chk(32'(pc), 32'(epc));
        chk(32'(stack_level), 32'(esp));
        chk(32'(fetch_addr), 32'(epc[12:0]));
        @(posedge hclk);
    endtask
    initial
    begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, ADDR_STACK_LEVEL_POINTER, 0, 32'h0000000F);
        foreach (rows[i])
            op(rows[i].k, rows[i].t, rows[i].pc, rows[i].sp);
        // Sixteen calls back to back fill every entry and bring the pointer round to empty again.
        for (int i = 0; i < 15; i++)
        begin
            u_core.issue(1, 15'(15'h4A30 + i));
            @(posedge hclk);
        end
        op(1, 15'h4A3F, 15'h4A3F, 4'hF);
        bus(1, ADDR_STACK_LEVEL_POINTER, 32'hFFFFFFF5, 0);
        bus(0, ADDR_STACK_LEVEL_POINTER, 0, 32'h00000005);
        bus(0, ADDR_STACK_TOP_LOW_BYTE, 0, 32'h00000035);
        bus(0, ADDR_STACK_TOP_HIGH_BYTE, 0, 32'h0000004A);
        bus(1, ADDR_STACK_TOP_HIGH_BYTE, 32'h000000FF, 0);
        bus(0, ADDR_STACK_TOP_HIGH_BYTE, 0, 32'h0000007F);
        bus(1, ADDR_STACK_TOP_LOW_BYTE, 32'h00000012, 0);
        bus(1, 16'h7FB0, 32'h000000AA, 0);
        bus(0, 16'h7FB0, 0, 32'h00000000);
        op(2, 0, 15'h7F12, 4'h4);
        for (int j = 4; j >= 0; j--)
            op(2, 0, (j == 0) ? 15'h0003 : 15'(15'h4A30 + j), 4'(j - 1));
        op(1, 15'h0123, 15'h0123, 4'h0);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk(32'(pc), 32'(RESET_VECTOR));
        chk(32'(stack_level), 32'(SP_EMPTY));
        chk(32'(hreadyout), 32'h1);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        op(0, 0, 15'h0001, 4'hF);
        // A return straight after a call must recover the address that call just saved.
        u_core.issue(1, 15'h0200);
        @(posedge hclk);
        op(2, 0, 15'h0002, 4'hF);
        op(5, 15'h0300, 15'h0004, 4'h0);
        op(2, 0, 15'h0002, 4'hF);
        op(1, 15'h0400, 15'h0400, 4'h0);
        op(6, 0, 15'h0003, 4'hF);
        tally_and_finish();
    end
endmodule
